// file: design/line_sampler.sv
/*
  Two-flop synchroniser for the clock and data lines plus edge, start and stop detection.
  Assumes asynchronous line levels; outputs lag the pins by two clocks.
*/
`timescale 1ns/1ps
module line_sampler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl,
  output logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  logic scl_meta_ff, scl_ff, scl_d_ff;
  logic sda_meta_ff, sda_ff, sda_d_ff;

  // idle bus is high, so reset to high to avoid a false start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_meta_ff <= 1'b1;
      scl_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_in;
      scl_ff <= scl_meta_ff;
      scl_d_ff <= scl_ff;
      sda_meta_ff <= sda_in;
      sda_ff <= sda_meta_ff;
      sda_d_ff <= sda_ff;
    end
  end

  // only the second and third flops are looked at
  assign scl = scl_ff;
  assign sda = sda_ff;
  assign scl_rise = scl_ff && !scl_d_ff;
  assign scl_fall = !scl_ff && scl_d_ff;
  assign start_seen = scl_ff && scl_d_ff && !sda_ff && sda_d_ff;
  assign stop_seen = scl_ff && scl_d_ff && sda_ff && !sda_d_ff;
endmodule

// file: design/two_wire_master.sv
/*
  Controller end: two-wire bus master driven by software over an axi4-lite slave.
  Assumes the device end may stretch the clock; the clock is made here by a divider.
*/
`timescale 1ns/1ps
`include "two_wire_defs.svh"
module two_wire_master import two_wire_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  two_wire_if.ctl bus,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  master_op_t op_ff;
  logic [1:0] ph_ff;
  logic [3:0] bit_ff;
  logic [8:0] out_ff, in_ff;
  logic [15:0] div_ff, tick_cnt_ff;
  logic scl_oe_ff, sda_oe_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, aw_ok_ff, w_ok_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [3:0] awaddr_ff, wstrb_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic scl_s, sda_s, do_wr, tick, cmd_wr;
  logic [2:0] cmd_op;

  function automatic logic mapped(input logic [3:0] a);
    mapped = a == `TW_AXI_CMD || a == `TW_AXI_STAT || a == `TW_AXI_DIV;
  endfunction

  line_sampler u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl_in(bus.scl),
    .sda_in(bus.sda),
    .scl(scl_s),
    .sda(sda_s),
    .scl_rise(),
    .scl_fall(),
    .start_seen(),
    .stop_seen()
  );

  assign do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign tick = tick_cnt_ff == 16'h0000;
  assign cmd_op = wdata_ff[10:8];
  // commands are taken only when idle and both low lanes are written
  assign cmd_wr = do_wr && awaddr_ff == `TW_AXI_CMD && wstrb_ff[1:0] == 2'b11 && op_ff == op_idle;

  // axi write channels, taken in either order, answered after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff <= s_axi_awaddr;
        aw_ok_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_ok_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= mapped(awaddr_ff) ? 2'b00 : 2'b10;
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // axi read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'b00;
      rdata_ff <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `TW_AXI_STAT: rdata_ff <= {16'h0000, in_ff[8:1], 6'h00, in_ff[0], op_ff != op_idle};
        `TW_AXI_DIV: rdata_ff <= {16'h0000, div_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // quarter-period divider register and tick counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 16'(`TW_QUARTER);
      tick_cnt_ff <= 16'h0000;
    end else begin
      if (do_wr && awaddr_ff == `TW_AXI_DIV) begin
        if (wstrb_ff[0]) div_ff[7:0] <= wdata_ff[7:0];
        if (wstrb_ff[1]) div_ff[15:8] <= wdata_ff[15:8];
      end
      tick_cnt_ff <= tick ? div_ff : tick_cnt_ff - 16'h0001;
    end
  end

  // bit engine: four quarter phases per start, stop or byte bit; waits in phase 2 while the slave stretches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_ff <= op_idle;
      ph_ff <= 2'b00;
      bit_ff <= 4'h0;
      out_ff <= 9'h1ff;
      in_ff <= 9'h000;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (cmd_wr) begin
      ph_ff <= 2'b00;
      bit_ff <= 4'h0;
      case (cmd_op)
        `TW_OP_START: op_ff <= op_start;
        `TW_OP_WRITE: begin
          op_ff <= op_byte;
          out_ff <= {wdata_ff[7:0], 1'b1};
        end
        `TW_OP_READ: begin
          op_ff <= op_byte;
          out_ff <= {8'hff, wdata_ff[`TW_CMD_NACK]};
        end
        `TW_OP_STOP: op_ff <= op_stop;
        default: op_ff <= op_idle;
      endcase
    end else if (op_ff != op_idle && tick && !(ph_ff == 2'b10 && !scl_s)) begin
      ph_ff <= ph_ff + 2'b01;
      case (op_ff)
        op_start: begin
          // from a held-low clock this is a repeated start
          case (ph_ff)
            2'b00: sda_oe_ff <= 1'b0;
            2'b01: scl_oe_ff <= 1'b0;
            2'b10: sda_oe_ff <= 1'b1;
            default: begin
              scl_oe_ff <= 1'b1;
              op_ff <= op_idle;
            end
          endcase
        end
        op_byte: begin
          case (ph_ff)
            2'b00: sda_oe_ff <= !out_ff[8];
            2'b01: scl_oe_ff <= 1'b0;
            2'b10: in_ff <= {in_ff[7:0], sda_s};
            default: begin
              scl_oe_ff <= 1'b1;
              out_ff <= {out_ff[7:0], 1'b1};
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == 4'h8) begin
                op_ff <= op_idle;
                sda_oe_ff <= 1'b0;
              end
            end
          endcase
        end
        op_stop: begin
          case (ph_ff)
            2'b00: sda_oe_ff <= 1'b1;
            2'b01: scl_oe_ff <= 1'b0;
            2'b10: sda_oe_ff <= 1'b0;
            default: op_ff <= op_idle;
          endcase
        end
        default: op_ff <= op_idle;
      endcase
    end
  end

  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_scl_oe = scl_oe_ff;
  assign bus.ctl_sda_oe = sda_oe_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rvalid = rvalid_ff;
endmodule

// file: design/two_wire_slave.sv
/*
  Device end: byte-oriented two-wire slave with status, data, own-address and control registers.
  Assumes a cpu register port on aclk and a master on the link that honours clock stretching.
*/
`timescale 1ns/1ps
`include "two_wire_defs.svh"
module two_wire_slave import two_wire_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  two_wire_if.dev bus,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic global_irq_en,
  input wire logic sleep_mode,
  output logic irq_req,
  output logic wake_req
);
  slave_state_t state_ff;
  logic flag_ff, ack_en_ff, start_req_ff, stop_req_ff, wcol_ff, en_ff, irq_en_ff;
  logic [7:0] own_ff, data_ff, code_ff, status_ff, shift_ff, rdata_ff;
  logic [3:0] cnt_ff;
  logic dir_rd_ff, gc_ff, last_ff, nack_ff, sda_oe_ff, scl_oe_ff;
  logic set_evt_ff, cap_ff, wake_ff, irq_ff;
  logic scl_s, sda_s, scl_r, scl_f, start_d, stop_d;
  logic wr_ctrl, wr_data, resume, hit;

  // general call is accepted only when enabled and only for writes
  function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] own);
    addr_hit = (b[7:1] == own[7:1]) || (b[7:1] == 7'h00 && own[0] && !b[0]);
  endfunction

  line_sampler u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl_in(bus.scl),
    .sda_in(bus.sda),
    .scl(scl_s),
    .sda(sda_s),
    .scl_rise(scl_r),
    .scl_fall(scl_f),
    .start_seen(start_d),
    .stop_seen(stop_d)
  );

  assign wr_ctrl = reg_wr && reg_addr == `TW_OFF_CTRL;
  assign wr_data = reg_wr && reg_addr == `TW_OFF_DATA;
  assign resume = wr_ctrl && reg_wdata[`TW_B_FLAG] && flag_ff;
  // recognition needs interface and ack enabled, no stop pending
  assign hit = en_ff && ack_en_ff && !stop_req_ff && addr_hit(shift_ff, own_ff);

  // control register; flag is write-one-to-clear and a hardware set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= 1'b0;
      ack_en_ff <= 1'b0;
      start_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
      en_ff <= 1'b0;
      irq_en_ff <= 1'b0;
    end else begin
      if (set_evt_ff) begin
        flag_ff <= 1'b1;
      end else if (resume) begin
        flag_ff <= 1'b0;
      end
      if (wr_ctrl) begin
        ack_en_ff <= reg_wdata[`TW_B_ACKEN];
        start_req_ff <= reg_wdata[`TW_B_START];
        en_ff <= reg_wdata[`TW_B_EN];
        irq_en_ff <= reg_wdata[`TW_B_IRQEN];
        // error recovery takes the stop request back, nothing else
        stop_req_ff <= reg_wdata[`TW_B_STOP] && !(resume && state_ff == st_err);
      end
    end
  end

  // own address register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_ff <= 8'h00;
    end else if (reg_wr && reg_addr == `TW_OFF_OWN) begin
      own_ff <= reg_wdata;
    end
  end

  // data register: software only while flag set, hardware captures bus bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_ff <= `TW_DATA_RST;
      wcol_ff <= 1'b0;
    end else begin
      if (wr_data) begin
        if (flag_ff) begin
          data_ff <= reg_wdata;
          wcol_ff <= 1'b0;
        end else begin
          wcol_ff <= 1'b1;
        end
      end
      // capture comes after the software write, so it wins when both land in one clock
      if (cap_ff) begin
        data_ff <= shift_ff;
      end
    end
  end

  // status follows the flag by one clock in both directions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= `TW_ST_IDLE;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= flag_ff ? code_ff : `TW_ST_IDLE;
      irq_ff <= flag_ff && irq_en_ff && global_irq_en;
    end
  end

  // read mux, registered; reads have no side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_ff <= 8'h00;
    end else begin
      case (reg_addr)
        `TW_OFF_STATUS: rdata_ff <= {status_ff[7:3], 3'b000};
        `TW_OFF_OWN: rdata_ff <= own_ff;
        `TW_OFF_DATA: rdata_ff <= data_ff;
        `TW_OFF_CTRL: rdata_ff <= {flag_ff, ack_en_ff, start_req_ff, stop_req_ff, wcol_ff, en_ff, 1'b0, irq_en_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // bus engine: acknowledge bits are produced here only, never by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= st_idle;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      code_ff <= `TW_ST_IDLE;
      dir_rd_ff <= 1'b0;
      gc_ff <= 1'b0;
      last_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      set_evt_ff <= 1'b0;
      cap_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      set_evt_ff <= 1'b0;
      cap_ff <= 1'b0;
      wake_ff <= 1'b0;
      if (!en_ff) begin
        state_ff <= st_idle;
        sda_oe_ff <= 1'b0;
        scl_oe_ff <= 1'b0;
      end else if ((start_d || stop_d) && state_ff != st_idle && state_ff != st_hold && state_ff != st_err) begin
        sda_oe_ff <= 1'b0;
        cnt_ff <= 4'h0;
        if (state_ff == st_rx && cnt_ff == 4'h1 && !nack_ff) begin
          // stop or repeated start in the high phase of a byte's first clock
          code_ff <= `TW_ST_SR_STOP;
          set_evt_ff <= 1'b1;
          state_ff <= start_d ? st_addr : st_idle;
        end else if (state_ff == st_addr && cnt_ff == 4'h0) begin
          state_ff <= start_d ? st_addr : st_idle;
        end else begin
          code_ff <= `TW_ST_BUSERR;
          set_evt_ff <= 1'b1;
          state_ff <= st_err;
        end
      end else begin
        case (state_ff)
          st_idle: begin
            // bus watched even while not addressed, so recognition can resume
            if (start_d) begin
              state_ff <= st_addr;
              cnt_ff <= 4'h0;
            end
          end
          st_addr: begin
            if (scl_r) begin
              shift_ff <= {shift_ff[6:0], sda_s};
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_f && cnt_ff == 4'h8) begin
              cnt_ff <= 4'h0;
              if (hit) begin
                sda_oe_ff <= 1'b1;
                dir_rd_ff <= shift_ff[0];
                gc_ff <= shift_ff[7:1] == 7'h00;
                nack_ff <= 1'b0;
                cap_ff <= !sleep_mode;
                wake_ff <= sleep_mode;
                state_ff <= st_ack;
                if (shift_ff[0]) begin
                  code_ff <= start_req_ff ? `TW_ST_ST_ADDR_ARB : `TW_ST_ST_ADDR;
                end else if (shift_ff[7:1] == 7'h00) begin
                  code_ff <= start_req_ff ? `TW_ST_SR_GC_ARB : `TW_ST_SR_GC;
                end else begin
                  code_ff <= start_req_ff ? `TW_ST_SR_ADDR_ARB : `TW_ST_SR_ADDR;
                end
              end else begin
                state_ff <= st_idle;
              end
            end
          end
          st_ack: begin
            // end of the acknowledge bit: raise the flag and stretch the clock
            if (scl_f) begin
              sda_oe_ff <= 1'b0;
              scl_oe_ff <= 1'b1;
              set_evt_ff <= 1'b1;
              state_ff <= st_hold;
            end
          end
          st_hold: begin
            if (resume) begin
              scl_oe_ff <= 1'b0;
              cnt_ff <= 4'h0;
              if (nack_ff) begin
                state_ff <= st_idle;
              end else if (dir_rd_ff) begin
                shift_ff <= data_ff;
                sda_oe_ff <= !data_ff[7];
                last_ff <= !reg_wdata[`TW_B_ACKEN]; // ack enable as written with the resume
                state_ff <= st_tx;
              end else begin
                state_ff <= st_rx;
              end
            end
          end
          st_rx: begin
            if (scl_r) begin
              shift_ff <= {shift_ff[6:0], sda_s};
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_f && cnt_ff == 4'h8) begin
              cnt_ff <= 4'h0;
              cap_ff <= 1'b1;
              // a cleared ack enable answers this byte with a not-acknowledge
              sda_oe_ff <= ack_en_ff;
              nack_ff <= !ack_en_ff;
              if (gc_ff) begin
                code_ff <= ack_en_ff ? `TW_ST_SR_GCDATA_ACK : `TW_ST_SR_GCDATA_NACK;
              end else begin
                code_ff <= ack_en_ff ? `TW_ST_SR_DATA_ACK : `TW_ST_SR_DATA_NACK;
              end
              state_ff <= st_ack;
            end
          end
          st_tx: begin
            if (scl_r) begin
              shift_ff <= {shift_ff[6:0], sda_s};
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_f) begin
              if (cnt_ff == 4'h8) begin
                sda_oe_ff <= 1'b0;
                cap_ff <= 1'b1;
                state_ff <= st_txack;
              end else begin
                sda_oe_ff <= !shift_ff[7];
              end
            end
          end
          st_txack: begin
            if (scl_r) begin
              // after the last byte the lines are released, so the master reads ones
              nack_ff <= sda_s || last_ff;
              code_ff <= sda_s ? `TW_ST_ST_DATA_NACK : (last_ff ? `TW_ST_ST_LAST_ACK : `TW_ST_ST_DATA_ACK);
            end else if (scl_f) begin
              scl_oe_ff <= 1'b1;
              set_evt_ff <= 1'b1;
              state_ff <= st_hold;
            end
          end
          st_err: begin
            // lines stay released and no stop is driven
            if (resume && reg_wdata[`TW_B_STOP]) begin
              state_ff <= st_idle;
            end
          end
          default: state_ff <= st_idle;
        endcase
      end
    end
  end

  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_oe = scl_oe_ff;
  assign bus.dev_sda_oe = sda_oe_ff;
  assign reg_rdata = rdata_ff;
  assign irq_req = irq_ff;
  assign wake_req = wake_ff;
endmodule

// file: inc/two_wire_defs.svh
/*
  Offsets, field positions, reset values, status codes and timing counts
  shared by both ends of the two-wire link.
  Assumes a 100 MHz core clock on both ends.
*/
`ifndef TWO_WIRE_DEFS_SVH
`define TWO_WIRE_DEFS_SVH

// device register index on its own 3-bit port
`define TW_OFF_STATUS 3'h1
`define TW_OFF_OWN 3'h2
`define TW_OFF_DATA 3'h3
`define TW_OFF_CTRL 3'h4
`define TW_DATA_RST 8'hff

// control register bit positions
`define TW_B_FLAG 7
`define TW_B_ACKEN 6
`define TW_B_START 5
`define TW_B_STOP 4
`define TW_B_WCOL 3
`define TW_B_EN 2
`define TW_B_IRQEN 0

// status codes
`define TW_ST_BUSERR 8'h00
`define TW_ST_SR_ADDR 8'h60
`define TW_ST_SR_ADDR_ARB 8'h68
`define TW_ST_SR_GC 8'h70
`define TW_ST_SR_GC_ARB 8'h78
`define TW_ST_SR_DATA_ACK 8'h80
`define TW_ST_SR_DATA_NACK 8'h88
`define TW_ST_SR_GCDATA_ACK 8'h90
`define TW_ST_SR_GCDATA_NACK 8'h98
`define TW_ST_SR_STOP 8'ha0
`define TW_ST_ST_ADDR 8'ha8
`define TW_ST_ST_ADDR_ARB 8'hb0
`define TW_ST_ST_DATA_ACK 8'hb8
`define TW_ST_ST_DATA_NACK 8'hc0
`define TW_ST_ST_LAST_ACK 8'hc8
`define TW_ST_IDLE 8'hf8

// controller register byte addresses (axi4-lite)
`define TW_AXI_CMD 4'h0
`define TW_AXI_STAT 4'h4
`define TW_AXI_DIV 4'h8

// controller command encodings, field positions
`define TW_OP_START 3'h1
`define TW_OP_WRITE 3'h2
`define TW_OP_READ 3'h3
`define TW_OP_STOP 3'h4
`define TW_CMD_NACK 11

// link timing
`define TW_CLK_NS 10
`define TW_SCL_NS 10000
`define TW_QUARTER (`TW_SCL_NS / (4 * `TW_CLK_NS))

`endif

// file: inc/two_wire_if.sv
/*
  Open-drain clock and data lines between the device end and the controller.
  Each end drives its own output and enable; the lines resolve here with pull-ups.
*/
`timescale 1ns/1ps
interface two_wire_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;

  // wired-and with pull-up: any enabled low driver wins
  assign scl = !((dev_scl_oe && !dev_scl_o) || (ctl_scl_oe && !ctl_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (ctl_sda_oe && !ctl_sda_o));

  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
  modport ctl (input scl, input sda, output ctl_scl_o, output ctl_scl_oe, output ctl_sda_o, output ctl_sda_oe);
endinterface

// file: inc/two_wire_pkg.sv
/*
  State and operation types of both link ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package two_wire_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_ack = 3'b010,
    st_hold = 3'b011,
    st_rx = 3'b100,
    st_tx = 3'b101,
    st_txack = 3'b110,
    st_err = 3'b111
  } slave_state_t;

  typedef enum logic [1:0] {
    op_idle = 2'b00,
    op_start = 2'b01,
    op_byte = 2'b10,
    op_stop = 2'b11
  } master_op_t;

endpackage

// file: sim/two_wire_bus_slave_and_status_tb_top.sv
/*
  Bench: controller end drives the link, device registers driven here.
  Assumes 100 MHz aclk; divider set to 8, a quarter period of 9 clocks.
*/
`timescale 1ns/1ps
module two_wire_bus_slave_and_status_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, reg_wr = 1'h0, global_irq_en = 1'h1, sleep_mode = 1'h0, woke = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic irq_req, wake_req, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_mismatch, num_checks;
  two_wire_if bus();
  two_wire_slave two_wire_slave_i(.*);
  two_wire_master two_wire_master_i(.*);
  two_wire_monitor two_wire_monitor_i(.*, .scl(bus.scl), .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe));
  // core clock
  initial forever #5 aclk = ~aclk;
  // a wake pulse is one clock wide, so latch it
  always @(posedge aclk) if (wake_req) woke <= 1'h1;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic dw(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge aclk);
    reg_wr <= 1'h0;
    @(posedge aclk);
  endtask
  // read mux lags the index by one clock
  task automatic dr(input logic [2:0] a);
    reg_addr <= a;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    v = {24'h0, reg_rdata};
    @(posedge aclk);
  endtask
  // ready is judged at the negedge, before the edge that takes it
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!tb);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end while (!tr);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic idle();
    axr(4'h4);
    for (int i = 0; i < 400 && v[0] !== 1'h0; i++) axr(4'h4);
  endtask
  task automatic wirq();
    for (int i = 0; i < 5000 && irq_req !== 1'h1; i++) @(negedge aclk);
    @(posedge aclk);
    chk("irq_req", 1, irq_req);
  endtask
  task automatic t_setup();
    axw(4'h8, 32'h8);
    dw(3'h2, 8'h55);
    dw(3'h4, 8'h45);
    dw(3'h3, 8'h11);
    dr(3'h4);
    chk("ctrl", 8'h4d, v);
    dr(3'h1);
    chk("status", 8'hf8, v);
    $display("setup test done");
  endtask
  task automatic t_recv();
    sleep_mode <= 1'h1;
    axw(4'h0, 32'h100);
    idle();
    axw(4'h0, 32'h254);
    wirq();
    sleep_mode <= 1'h0;
    dr(3'h1);
    chk("status", 8'h60, v);
    dr(3'h3);
    chk("data", 8'hff, v);
    chk("woke", 1, woke);
    chk("dev_scl_oe", 1, bus.dev_scl_oe);
    global_irq_en <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("irq_req", 0, irq_req);
    global_irq_en <= 1'h1;
    idle();
    chk("nack", 0, v[1]);
    dw(3'h4, 8'hc5);
    axw(4'h0, 32'h2a5);
    wirq();
    dr(3'h1);
    chk("status", 8'h80, v);
    dr(3'h3);
    chk("data", 8'ha5, v);
    $display("receive test done");
  endtask
  task automatic t_xmit();
    idle();
    dw(3'h4, 8'hc5);
    axw(4'h0, 32'h100);
    wirq();
    idle();
    dw(3'h4, 8'hc5);
    axw(4'h0, 32'h255);
    wirq();
    dr(3'h1);
    chk("status", 8'ha8, v);
    dw(3'h3, 8'h3c);
    dr(3'h4);
    chk("ctrl", 8'hc5, v);
    idle();
    dw(3'h4, 8'h85);
    axw(4'h0, 32'hb00);
    wirq();
    dr(3'h1);
    chk("status", 8'hc0, v);
    idle();
    chk("rx", 8'h3c, v[15:8]);
    dw(3'h4, 8'hc5);
    axw(4'h0, 32'h100);
    idle();
    axw(4'h0, 32'h400);
    wirq();
    dr(3'h1);
    chk("status", 8'h00, v);
    dw(3'h4, 8'hd5);
    dr(3'h4);
    chk("ctrl", 8'h45, v);
    $display("transmit test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_setup();
    t_recv();
    t_xmit();
    results();
  end
  // hang guard, well past the expected run
  initial begin
    repeat (80000) @(posedge aclk);
    n_mismatch++;
    results();
  end
endmodule

// file: sim/two_wire_monitor.sv
/*
  Checker of the link lines and the device irq and status ports.
  Assumes one aclk domain with sync active-low aresetn.
*/
`timescale 1ns/1ps
module two_wire_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic global_irq_en,
  input wire logic sleep_mode
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // reads are registered, so the status index is the previous one
  AST_IRQ_GATE: assert property (irq_req |-> $past(global_irq_en))
    else $error("irq gate");
  AST_STAT_LOW: assert property ($past(reg_addr) == 3'h1 |-> reg_rdata[2:0] == 3'h0)
    else $error("status low bits");
  AST_IDLE_IRQ: assert property ($past(reg_addr) == 3'h1 && reg_rdata == 8'hf8 |-> !$past(irq_req))
    else $error("irq on idle");
  AST_BUS_ERR: assert property ($past(aresetn) && $past(reg_addr) == 3'h1 && reg_rdata == 8'h00
    |-> !dev_scl_oe && !dev_sda_oe) else $error("bus error lines");
  AST_WAKE_SLP: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake awake");
  AST_WAKE_ONE: assert property (wake_req |=> !wake_req)
    else $error("wake width");
  // data only moves while the clock line is low
  AST_ACK_EDGE: assert property ($changed(dev_sda_oe) |-> !$past(scl))
    else $error("sda moved");
  AST_SCL_HOLD: assert property ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("scl grab");
endmodule
